// >>> core/lnbt_pkg.sv
/*
  Shared constants of the supply-channel tone and overcurrent control:
  register offsets, field positions, reset values and timing counts.
  Assumes a 250 MHz register clock and a 22 kHz nominal tone.
*/
package lnbt_pkg;

  // ==========================================================
  // timebase
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned TONE_HZ = 22_000;
  localparam int unsigned TONE_MIN_HZ = 17_600;
  localparam int unsigned BOOST_MULT = 16;
  localparam int unsigned OCT_MS = 48;
  // pclk cycles per half period of the boost clock
  localparam int unsigned BOOST_HALF = CLK_HZ / (TONE_HZ * BOOST_MULT * 2);
  // boost clock periods in the overcurrent limit
  localparam int unsigned OCT_TICKS = OCT_MS * TONE_HZ * BOOST_MULT / 1000;
  // longest tone period at the slowest captured tone, rounded up
  localparam int unsigned DET_CYC = (CLK_HZ + TONE_MIN_HZ - 1) / TONE_MIN_HZ;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] ISTAT_OFS = 8'h08;
  localparam logic [7:0] IMASK_OFS = 8'h0c;

  // control fields
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_TIMER_BIT = 4;
  localparam int unsigned CTRL_SRC_BIT = 5;
  localparam int unsigned CTRL_GATE_BIT = 6;

  // live status fields
  localparam int unsigned STAT_OC_BIT = 0;
  localparam int unsigned STAT_OFF_BIT = 1;
  localparam int unsigned STAT_TPF_BIT = 2;
  localparam int unsigned STAT_TONE_PRESENT_FLAG_BIT = 3;

  // interrupt status and mask fields
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_OC_BIT = 0;
  localparam int unsigned IRQ_SHUT_BIT = 1;
  localparam int unsigned IRQ_TONE_PRESENT_FLAG_BIT = 2;

  // reset values
  localparam logic CTRL_RST = 1'b0;
  localparam logic [2:0] IMASK_RST = 3'h0;
  localparam logic [3:0] PHASE_RST = 4'h0;

endpackage

// >>> core/lnbt_act_det.sv
/*
  Activity detector: reports a level input as active from its first
  rising edge until no rising edge has been seen for LIMIT cycles.
  Assumes the input is already synchronised to clk.
*/
`timescale 1ns/10ps
module lnbt_act_det #(
  parameter int unsigned LIMIT = lnbt_pkg::DET_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic level,
  output logic active
);

  localparam int unsigned CW = $clog2(LIMIT + 1);

  typedef struct packed {
    logic prev;
    logic act;
    logic [CW-1:0] cnt;
  } lnbt_det_t;

  lnbt_det_t st_reg;
  lnbt_det_t st_next;

  // ==========================================================
  // edge watch
  always_comb begin
    st_next = st_reg;
    st_next.prev = level;
    if (level && !st_reg.prev) begin
      st_next.act = 1'b1;
      st_next.cnt = '0;
    end else if (st_reg.act) begin
      if (st_reg.cnt == CW'(LIMIT - 1)) begin
        st_next.act = 1'b0;
      end else begin
        st_next.cnt = st_reg.cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign active = st_reg.act;

endmodule

// >>> core/lnbt_ctrl.sv
/*
  One supply channel's digital control: overcurrent shutdown timer,
  boost switching clock and internal tone from one timebase, tone
  source selection and gating, tone detector open-drain output, and an
  APB register slave with a masked interrupt.
  Assumes pins arrive asynchronously and are synchronised here; the
  analog stage obeys lnb_out_en and the modulation outputs.
*/
// Function
// - sustained 48 ms overcurrent disables output, flags it
// - after shutdown stay off until re-enabled
// - boost clock is sixteen times tone, shared
// - detector lags tone by at most one slowest tone period
// - detector pin pulls low while tone present
// - source select: 1 internal, 0 external pin
// - gate bit and pin together gate the internal tone; external tone by gate bit only
// - stopped external pin parks output by level
// - tone present flag set while tone generated
// - control bit 4 enables the shutdown timer
// - overcurrent raises interrupt only with timer enabled
// - all control settings reset to zero
`timescale 1ns/10ps
module lnbt_ctrl #(
  parameter int unsigned OCT_TICKS = lnbt_pkg::OCT_TICKS,
  parameter int unsigned DET_CYC = lnbt_pkg::DET_CYC,
  parameter int unsigned BOOST_HALF = lnbt_pkg::BOOST_HALF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic overcurrent_in,
  input wire logic external_tone_input,
  input wire logic tone_rx_in,
  output logic lnb_out_en,
  output logic boost_clk_out,
  output logic tone_mod_en,
  output logic tone_mod_lvl,
  output logic tone_det_o,
  output logic tone_det_oe_n,
  output logic irq
);

  localparam int unsigned OW = $clog2(OCT_TICKS + 1);
  localparam int unsigned BW = $clog2(BOOST_HALF + 1);
  localparam int unsigned IW = lnbt_pkg::IRQ_W;

  typedef struct packed {
    logic oc_s1;
    logic oc_s2;
    logic ext_s1;
    logic ext_s2;
    logic rx_s1;
    logic rx_s2;
    logic ctrl_en;
    logic timer_en;
    logic src_sel;
    logic gate;
    logic [BW-1:0] boost_cnt;
    logic boost_clk;
    logic [3:0] tone_ph;
    logic int_tone;
    logic [OW-1:0] oc_cnt;
    logic tpf;
    logic oc_prev;
    logic det_prev;
    logic [IW-1:0] istat;
    logic [IW-1:0] imask;
    logic [31:0] rdata;
    logic rdy;
    logic err;
    logic out_en;
    logic mod_en;
    logic mod_lvl;
    logic det_oe_n;
    logic det_lvl;
    logic irq;
  } lnbt_state_t;

  lnbt_state_t st_reg;
  lnbt_state_t st_next;

  logic ext_act;
  logic det_act;

  // ==========================================================
  // address decode, shared by reads and writes
  function automatic logic [3:0] lnbt_dec(input logic [7:0] a);
    lnbt_dec = 4'h0;
    unique case (a)
      lnbt_pkg::CTRL_OFS: lnbt_dec = 4'h1;
      lnbt_pkg::STAT_OFS: lnbt_dec = 4'h2;
      lnbt_pkg::ISTAT_OFS: lnbt_dec = 4'h4;
      lnbt_pkg::IMASK_OFS: lnbt_dec = 4'h8;
      default: lnbt_dec = 4'h0;
    endcase
  endfunction

  // ==========================================================
  // activity of the external tone pin and of the received tone
  lnbt_act_det #(.LIMIT(DET_CYC)) u_ext_det (
    .clk(pclk),
    .rst_n(presetn),
    .level(st_reg.ext_s2),
    .active(ext_act)
  );

  lnbt_act_det #(.LIMIT(DET_CYC)) u_rx_det (
    .clk(pclk),
    .rst_n(presetn),
    .level(st_reg.rx_s2),
    .active(det_act)
  );

  // ==========================================================
  // next state
  always_comb begin
    logic half_tick;
    logic rise_tick;
    logic oc_on;
    logic shut;
    logic gen;
    logic [3:0] sel;
    logic acc;
    logic [IW-1:0] set;
    logic [IW-1:0] clr;
    logic [31:0] rd;
    half_tick = 1'b0;
    rise_tick = 1'b0;
    oc_on = 1'b0;
    shut = 1'b0;
    gen = 1'b0;
    sel = 4'h0;
    acc = 1'b0;
    set = '0;
    clr = '0;
    rd = '0;
    st_next = st_reg;

    // pin synchronisers
    st_next.oc_s1 = overcurrent_in;
    st_next.oc_s2 = st_reg.oc_s1;
    st_next.ext_s1 = external_tone_input;
    st_next.ext_s2 = st_reg.ext_s1;
    st_next.rx_s1 = tone_rx_in;
    st_next.rx_s2 = st_reg.rx_s1;

    // boost clock and internal tone from one divider
    half_tick = (st_reg.boost_cnt == BW'(BOOST_HALF - 1));
    rise_tick = half_tick && !st_reg.boost_clk;
    if (half_tick) begin
      st_next.boost_cnt = '0;
      st_next.boost_clk = !st_reg.boost_clk;
      st_next.tone_ph = st_reg.tone_ph + 4'h1;
      if (st_reg.tone_ph == 4'hf) begin
        st_next.int_tone = !st_reg.int_tone;
      end
    end else begin
      st_next.boost_cnt = st_reg.boost_cnt + BW'(1);
    end

    // overcurrent shutdown timer on the boost timebase
    oc_on = st_reg.oc_s2 && st_reg.timer_en && st_reg.ctrl_en;
    if (!oc_on) begin
      st_next.oc_cnt = '0;
    end else if (rise_tick) begin
      if (st_reg.oc_cnt == OW'(OCT_TICKS)) begin
        shut = 1'b1;
        st_next.oc_cnt = '0;
      end else begin
        st_next.oc_cnt = st_reg.oc_cnt + OW'(1);
      end
    end

    // tone source and gating
    if (st_reg.src_sel) begin
      st_next.mod_en = st_reg.gate && st_reg.ext_s2;
      st_next.mod_lvl = st_reg.int_tone;
      gen = st_reg.gate && st_reg.ext_s2;
    end else begin
      st_next.mod_en = st_reg.gate;
      st_next.mod_lvl = st_reg.ext_s2;
      gen = st_reg.gate && ext_act;
    end
    st_next.tpf = gen;

    // detector output, pulled low while a tone is present
    st_next.det_oe_n = !det_act;
    // open-drain pin only ever pulls low
    st_next.det_lvl = 1'b0;

    // event sources
    st_next.oc_prev = st_reg.oc_s2;
    st_next.det_prev = det_act;
    if (st_reg.oc_s2 && !st_reg.oc_prev && st_reg.timer_en) begin
      set[lnbt_pkg::IRQ_OC_BIT] = 1'b1;
    end
    set[lnbt_pkg::IRQ_SHUT_BIT] = shut;
    set[lnbt_pkg::IRQ_TONE_PRESENT_FLAG_BIT] = det_act && !st_reg.det_prev;

    // apb: answer prepared in setup, taken in the one access cycle
    sel = lnbt_dec(paddr);
    acc = psel && penable && st_reg.rdy;
    rd[lnbt_pkg::CTRL_EN_BIT] = st_reg.ctrl_en;
    rd[lnbt_pkg::CTRL_TIMER_BIT] = st_reg.timer_en;
    rd[lnbt_pkg::CTRL_SRC_BIT] = st_reg.src_sel;
    rd[lnbt_pkg::CTRL_GATE_BIT] = st_reg.gate;
    st_next.rdata = '0;
    unique case (1'b1)
      sel[0]: st_next.rdata = rd;
      sel[1]: begin
        st_next.rdata[lnbt_pkg::STAT_OC_BIT] = st_reg.oc_s2;
        st_next.rdata[lnbt_pkg::STAT_OFF_BIT] = !st_reg.out_en;
        st_next.rdata[lnbt_pkg::STAT_TPF_BIT] = st_reg.tpf;
        st_next.rdata[lnbt_pkg::STAT_TONE_PRESENT_FLAG_BIT] = det_act;
      end
      sel[2]: st_next.rdata[IW-1:0] = st_reg.istat;
      sel[3]: st_next.rdata[IW-1:0] = st_reg.imask;
      default: st_next.rdata = '0;
    endcase
    st_next.rdy = psel && !penable;
    st_next.err = psel && !penable && (sel == 4'h0);
    if (!(psel && !penable)) begin
      st_next.rdata = '0;
    end

    if (acc && pwrite && sel[0]) begin
      st_next.ctrl_en = pwdata[lnbt_pkg::CTRL_EN_BIT];
      st_next.timer_en = pwdata[lnbt_pkg::CTRL_TIMER_BIT];
      st_next.src_sel = pwdata[lnbt_pkg::CTRL_SRC_BIT];
      st_next.gate = pwdata[lnbt_pkg::CTRL_GATE_BIT];
    end
    if (acc && pwrite && sel[2]) begin
      clr = pwdata[IW-1:0];
    end
    if (acc && pwrite && sel[3]) begin
      st_next.imask = pwdata[IW-1:0];
    end

    // shutdown drops the enable; software must write it again
    if (shut) begin
      st_next.ctrl_en = 1'b0;
    end
    st_next.out_en = st_next.ctrl_en;

    // sticky status, a new event beats a same-cycle clear
    st_next.istat = (st_reg.istat & ~clr) | set;
    st_next.irq = |(st_next.istat & st_next.imask);
  end

  // ==========================================================
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.ctrl_en <= lnbt_pkg::CTRL_RST;
      st_reg.timer_en <= lnbt_pkg::CTRL_RST;
      st_reg.src_sel <= lnbt_pkg::CTRL_RST;
      st_reg.gate <= lnbt_pkg::CTRL_RST;
      st_reg.imask <= lnbt_pkg::IMASK_RST;
      st_reg.tone_ph <= lnbt_pkg::PHASE_RST;
      st_reg.det_oe_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // outputs
  assign prdata = st_reg.rdata;
  assign pready = st_reg.rdy;
  assign pslverr = st_reg.err;
  assign lnb_out_en = st_reg.out_en;
  assign boost_clk_out = st_reg.boost_clk;
  assign tone_mod_en = st_reg.mod_en;
  assign tone_mod_lvl = st_reg.mod_lvl;
  assign tone_det_o = st_reg.det_lvl;
  assign tone_det_oe_n = st_reg.det_oe_n;
  assign irq = st_reg.irq;

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  shut_on_limit_a: assert property (
    (st_reg.oc_s2 && st_reg.timer_en && st_reg.ctrl_en && st_reg.boost_clk == 1'b0
     && st_reg.boost_cnt == BW'(BOOST_HALF - 1) && st_reg.oc_cnt == OW'(OCT_TICKS))
    |=> (!lnb_out_en && st_reg.istat[lnbt_pkg::IRQ_SHUT_BIT] && !st_reg.ctrl_en))
    else $error("overcurrent limit did not shut the channel");

  stay_off_a: assert property (
    (!st_reg.ctrl_en && !(psel && penable && pwrite && paddr == lnbt_pkg::CTRL_OFS))
    |=> !st_reg.ctrl_en ##0 (!lnb_out_en))
    else $error("channel came back without a re-enable");

  timer_clear_a: assert property (
    !st_reg.oc_s2 |=> st_reg.oc_cnt == '0)
    else $error("overcurrent timer kept counting after overcurrent ended");

  boost_wrap_a: assert property (
    $changed(st_reg.boost_clk) |-> $past(st_reg.boost_cnt) == BW'(BOOST_HALF - 1))
    else $error("boost clock half period wrong");

  tone_ratio_a: assert property (
    $changed(st_reg.int_tone) |-> $past(st_reg.tone_ph) == 4'hf && $changed(st_reg.boost_clk))
    else $error("internal tone not sixteen boost periods");

  int_source_a: assert property (
    (st_reg.src_sel && st_reg.gate && st_reg.ext_s2)
    |=> tone_mod_en && tone_mod_lvl == $past(st_reg.int_tone))
    else $error("internal tone not passed when gated on");

  gate_off_a: assert property (
    (!st_reg.gate || (st_reg.src_sel && !st_reg.ext_s2)) |=> !tone_mod_en)
    else $error("tone emitted while gated off");

  ext_park_a: assert property (
    (!st_reg.src_sel && st_reg.gate) |=> tone_mod_en && tone_mod_lvl == $past(st_reg.ext_s2))
    else $error("external level not passed or parked");

  tone_flag_a: assert property (
    (st_reg.gate && (st_reg.src_sel ? st_reg.ext_s2 : ext_act)) |=> st_reg.tpf)
    else $error("tone present flag missing");

  det_pin_a: assert property (
    det_act |=> !tone_det_oe_n ##1 (tone_det_oe_n == !$past(det_act)))
    else $error("detector pin does not follow the detector");

  oc_irq_gate_a: assert property (
    ($rose(st_reg.oc_s2) && !st_reg.timer_en && !st_reg.istat[lnbt_pkg::IRQ_OC_BIT])
    |=> !st_reg.istat[lnbt_pkg::IRQ_OC_BIT])
    else $error("overcurrent interrupt raised with timer off");

  irq_level_a: assert property (
    irq == |(st_reg.istat & st_reg.imask))
    else $error("interrupt output disagrees with status and mask");

  shut_c: cover property (st_reg.istat[lnbt_pkg::IRQ_SHUT_BIT] && !lnb_out_en);
  int_tone_c: cover property (st_reg.src_sel && tone_mod_en ##1 $changed(tone_mod_lvl));
  ext_park_c: cover property (!st_reg.src_sel && tone_mod_en && !tone_mod_lvl);
  det_c: cover property ($fell(tone_det_oe_n));

endmodule

// >>> dv/lnbt_far_model.sv
/*
  Far-side model: the converter on the cable. It loads the channel
  output (overcurrent while shorted and powered) and returns a
  digitised received tone.
  Assumes commands from the bench and one clock shared with the block.
*/
`timescale 1ns/10ps
module lnbt_far_model #(
  parameter int TONE_HALF = 40
) (
  input wire logic clk,
  input wire logic lnb_out_en,
  input wire logic short_cmd,
  input wire logic tone_cmd,
  output logic overcurrent_in,
  output logic tone_rx_in
);
  // ==========================================================
  // load and tone return
  int cnt;
  // a short only draws current while the output is powered
  assign overcurrent_in = short_cmd & lnb_out_en;
  always @(posedge clk) begin
    if (!tone_cmd) begin
      cnt <= 0;
      tone_rx_in <= 1'b0;
    end else if (cnt == TONE_HALF - 1) begin
      cnt <= 0;
      tone_rx_in <= ~tone_rx_in;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// >>> dv/lnb_tone_and_overcurrent_control_tb.sv
/*
  Self-checking bench of one supply channel control block: APB tasks,
  shutdown timing, tone selection table, boost clock and detector.
  Assumes the far-side model file and scaled timing parameters.
*/
`timescale 1ns/10ps
module lnb_tone_and_overcurrent_control_tb;
  localparam int OCT = 20;
  localparam int DET = 100;
  localparam int BH = 4;
  localparam int TH = 40;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, overcurrent_in, tone_rx_in, err;
  logic external_tone_input = 0, short_cmd = 0, tone_cmd = 0;
  logic lnb_out_en, boost_clk_out, tone_mod_en, tone_mod_lvl;
  logic tone_det_o, tone_det_oe_n, irq, s, g, p;
  int fails = 0, checks_done = 0, n, m;

  always #2 pclk = ~pclk;

  lnbt_ctrl #(.OCT_TICKS(OCT), .DET_CYC(DET), .BOOST_HALF(BH)) u_lnbt_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .overcurrent_in(overcurrent_in),
    .external_tone_input(external_tone_input), .tone_rx_in(tone_rx_in),
    .lnb_out_en(lnb_out_en), .boost_clk_out(boost_clk_out),
    .tone_mod_en(tone_mod_en), .tone_mod_lvl(tone_mod_lvl),
    .tone_det_o(tone_det_o), .tone_det_oe_n(tone_det_oe_n), .irq(irq));

  lnbt_far_model #(.TONE_HALF(TH)) u_lnbt_far_model (
    .clk(pclk), .lnb_out_en(lnb_out_en), .short_cmd(short_cmd),
    .tone_cmd(tone_cmd), .overcurrent_in(overcurrent_in), .tone_rx_in(tone_rx_in));

  // ==========================================================
  // tasks
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    chk("pready", pready, 1);
    psel <= 0; penable <= 0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask

  task rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(nm, rd, exp);
  endtask

  // counts edges until sig reaches v, capped at lim
  task automatic wait_lvl(ref logic sig, input logic v, input int lim);
    n = 0;
    while (sig !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
  endtask

  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================
  // watchdog
  initial begin
    #(4 * 60000);
    fails++;
    finish_test();
  end

  // ==========================================================
  // tests
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk("lnb_out_en", lnb_out_en, 0);
    chk("tone_det_oe_n", tone_det_oe_n, 1);
    rdchk("ctrl", lnbt_pkg::CTRL_OFS, 0);
    rdchk("imask", lnbt_pkg::IMASK_OFS, 0);
    rdchk("istat", lnbt_pkg::ISTAT_OFS, 0);
    xfer(8'h10, 1'b0, 32'h0);
    chk("slverr", err, 1);
    chk("unmapped", rd, 0);
    $display("test reset done");

    wr(lnbt_pkg::IMASK_OFS, 32'h7);
    wr(lnbt_pkg::CTRL_OFS, 32'h11);
    repeat (3) @(posedge pclk);
    chk("enabled", lnb_out_en, 1);
    short_cmd <= 1;
    repeat ((OCT - 4) * 2 * BH) @(posedge pclk);
    short_cmd <= 0;
    repeat ((OCT + 4) * 2 * BH) @(posedge pclk);
    chk("brief overload", lnb_out_en, 1);
    wr(lnbt_pkg::ISTAT_OFS, 32'h7);
    short_cmd <= 1;
    wait_lvl(lnb_out_en, 1'b0, (OCT + 4) * 2 * BH);
    chk("shut not early", 32'(n >= OCT * 2 * BH), 1);
    chk("shut in time", lnb_out_en, 0);
    rdchk("istat shut", lnbt_pkg::ISTAT_OFS, 32'h3);
    chk("irq", irq, 1);
    rdchk("ctrl off", lnbt_pkg::CTRL_OFS, 32'h10);
    rdchk("status off", lnbt_pkg::STAT_OFS, 32'h2);
    short_cmd <= 0;
    repeat (500) @(posedge pclk);
    chk("stays off", lnb_out_en, 0);
    wr(lnbt_pkg::ISTAT_OFS, 32'h3);
    rdchk("istat clr", lnbt_pkg::ISTAT_OFS, 0);
    chk("irq clr", irq, 0);
    wr(lnbt_pkg::CTRL_OFS, 32'h11);
    repeat (3) @(posedge pclk);
    chk("re-enabled", lnb_out_en, 1);
    $display("test shutdown done");

    wr(lnbt_pkg::CTRL_OFS, 32'h01);
    short_cmd <= 1;
    repeat ((OCT + 8) * 2 * BH) @(posedge pclk);
    chk("timer off", lnb_out_en, 1);
    rdchk("no latch", lnbt_pkg::ISTAT_OFS, 0);
    chk("no irq", irq, 0);
    short_cmd <= 0;
    $display("test timer off done");

    wait_lvl(boost_clk_out, 1'b0, 50);
    wait_lvl(boost_clk_out, 1'b1, 50);
    wait_lvl(boost_clk_out, 1'b0, 50);
    m = n;
    wait_lvl(boost_clk_out, 1'b1, 50);
    chk("boost period", m + n, 2 * BH);
    for (int i = 0; i < 8; i++) begin
      {s, g, p} = 3'(i);
      wr(lnbt_pkg::CTRL_OFS, {25'h0, g, s, 5'h01});
      external_tone_input <= p;
      repeat (2 * DET + 8) @(posedge pclk);
      chk("mod_en", tone_mod_en, g & (s ? p : 1'b1));
      if (!s && g) chk("park", tone_mod_lvl, p);
      xfer(lnbt_pkg::STAT_OFS, 1'b0, 32'h0);
      chk("tone flag", rd[2], s & g & p);
    end
    wait_lvl(tone_mod_lvl, !tone_mod_lvl, 200);
    wait_lvl(tone_mod_lvl, !tone_mod_lvl, 200);
    chk("tone half", n, 16 * BH);
    wr(lnbt_pkg::CTRL_OFS, 32'h41);
    for (int i = 0; i < 6; i++) begin
      repeat (TH) @(posedge pclk);
      external_tone_input <= !external_tone_input;
    end
    repeat (4) @(posedge pclk);
    chk("ext follow", tone_mod_lvl, external_tone_input);
    rdchk("ext flag", lnbt_pkg::STAT_OFS, 32'h4);
    $display("test tone generation done");

    wr(lnbt_pkg::ISTAT_OFS, 32'h7);
    tone_cmd <= 1;
    wait_lvl(tone_det_oe_n, 1'b0, 2 * TH + 8);
    chk("detect", tone_det_oe_n, 0);
    chk("pin level", tone_det_o, 0);
    rdchk("istat det", lnbt_pkg::ISTAT_OFS, 32'h4);
    chk("irq det", irq, 1);
    xfer(lnbt_pkg::STAT_OFS, 1'b0, 32'h0);
    chk("status det", rd[3], 1);
    repeat (3 * TH) @(posedge pclk);
    chk("detect holds", tone_det_oe_n, 0);
    tone_cmd <= 0;
    wait_lvl(tone_det_oe_n, 1'b1, DET + 2 * TH + 16);
    chk("release", tone_det_oe_n, 1);
    $display("test detector done");
    finish_test();
  end
endmodule
